// *** hw/dsw_wiper_ctrl.sv ***
`timescale 1ns/1ps
module dsw_wiper_ctrl (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic interface_select_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    output logic sdo_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [dsw_pkg::CODE_W-1:0] wiper_code_o,
    output logic shutdown_o,
    output logic [dsw_pkg::CODE_W-1:0] tap_a_dist_o
);
    import dsw_pkg::*;

    // Address byte hit: fixed high bits plus strap level
    function automatic logic addr_hit(input logic [7:0] b, input logic strap);
        return b[7:1] == {ADDR_HIGH, strap};
    endfunction : addr_hit

    // Synchronised pins
    logic [4:0] pins_s;
    logic sel_s, cs_s, clk_s, dat_s;
    // Previous samples for edge finding
    logic clk_d_r, cs_d_r, dat_d_r;
    logic clk_rise, clk_fall, cs_rise, start_c, stop_c;
    // Shift register shared by both protocols
    logic [7:0] shift_r;
    logic [7:0] wiper_code_r;
    logic shutdown_r;
    // I2C slave state
    dsw_phase_t phase_r;
    logic [3:0] bit_cnt_r;
    logic ack_slot_r;
    // Read bit drive window
    logic rd_en_r;
    logic rs_pend_r, sd_pend_r;
    logic [7:0] tx_r;

    dsw_sync u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .async_i({interface_select_i, cs_n_i, sclk_i, sdi_i, 1'b1}),
        .sync_o(pins_s)
    );
    assign sel_s = pins_s[4];
    assign cs_s = pins_s[3];
    assign clk_s = pins_s[2];
    assign dat_s = pins_s[1];

    // Edge history of synchronised pins
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            clk_d_r <= 1'b1;
            cs_d_r <= 1'b1;
            dat_d_r <= 1'b1;
        end else begin
            clk_d_r <= clk_s;
            cs_d_r <= cs_s;
            dat_d_r <= dat_s;
        end
    end

    assign clk_rise = clk_s & ~clk_d_r;
    assign clk_fall = ~clk_s & clk_d_r;
    assign cs_rise = cs_s & ~cs_d_r;
    // Start and stop: data moves while clock high
    assign start_c = clk_s & clk_d_r & dat_d_r & ~dat_s;
    assign stop_c = clk_s & clk_d_r & ~dat_d_r & dat_s;

    // Shift register; also the daisy-chain source
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            shift_r <= 8'h00;
        end else if (sel_s == SEL_SPI) begin
            if (!cs_s && clk_rise) begin
                shift_r <= {shift_r[6:0], dat_s};
            end
        end else if (start_c) begin
            shift_r <= 8'h00;
        end else if (clk_rise && bit_cnt_r < BITS_PER_BYTE) begin
            shift_r <= {shift_r[6:0], dat_s};
        end
    end

    // I2C phase and bit counter; ninth clock is the ack slot
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            phase_r <= DSW_IDLE;
            bit_cnt_r <= 4'h0;
            rs_pend_r <= 1'b0;
            sd_pend_r <= 1'b0;
        end else if (sel_s != SEL_I2C || stop_c) begin
            phase_r <= DSW_IDLE;
            bit_cnt_r <= 4'h0;
        end else if (start_c) begin
            phase_r <= DSW_ADDR;
            bit_cnt_r <= 4'h0;
        end else if (clk_fall && bit_cnt_r == ACK_SLOT) begin
            // End of ninth clock: byte fully handled
            bit_cnt_r <= 4'h0;
            case (phase_r)
                DSW_ADDR: begin
                    if (addr_hit(shift_r, cs_s)) begin
                        phase_r <= shift_r[ADDR_RW_POS] ? DSW_RDATA : DSW_INSTR;
                    end else begin
                        phase_r <= DSW_IGNORE;
                    end
                end
                DSW_INSTR: begin
                    rs_pend_r <= shift_r[INSTR_RS_POS];
                    sd_pend_r <= shift_r[INSTR_SD_POS];
                    phase_r <= DSW_WDATA;
                end
                DSW_WDATA: phase_r <= DSW_IGNORE;
                DSW_RDATA: phase_r <= DSW_IGNORE;
                default: phase_r <= phase_r;
            endcase
        // Counts the ack clock too, so the ninth fall is seen
        end else if (clk_rise && bit_cnt_r < ACK_SLOT && phase_r != DSW_IDLE) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // Ack is driven during ninth clock of accepted bytes
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ack_slot_r <= 1'b0;
        end else if (sel_s != SEL_I2C || start_c || stop_c) begin
            ack_slot_r <= 1'b0;
        end else if (clk_fall && bit_cnt_r == ACK_SLOT) begin
            ack_slot_r <= 1'b0;
        // ack from eighth fall to ninth fall
        end else if (clk_fall && bit_cnt_r == BITS_PER_BYTE) begin
            case (phase_r)
                DSW_ADDR: ack_slot_r <= addr_hit(shift_r, cs_s);
                DSW_INSTR: ack_slot_r <= 1'b1;
                DSW_WDATA: ack_slot_r <= 1'b1;
                default: ack_slot_r <= 1'b0;
            endcase
        end
    end

    // Read drive window: address ack end to eighth fall
    // Released while clock is low, so no false stop is made
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rd_en_r <= 1'b0;
        end else if (sel_s != SEL_I2C || start_c || stop_c) begin
            rd_en_r <= 1'b0;
        end else if (clk_fall && bit_cnt_r == ACK_SLOT && phase_r == DSW_ADDR) begin
            rd_en_r <= addr_hit(shift_r, cs_s) & shift_r[ADDR_RW_POS];
        end else if (clk_fall && bit_cnt_r == BITS_PER_BYTE) begin
            rd_en_r <= 1'b0;
        end
    end

    // Read data shifter, loaded as the address ack ends
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            tx_r <= 8'h00;
        end else if (clk_fall && bit_cnt_r == ACK_SLOT && phase_r == DSW_ADDR) begin
            tx_r <= wiper_code_r;
        end else if (clk_fall && phase_r == DSW_RDATA && bit_cnt_r != 4'h0) begin
            tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    // Wiper code: preset, SPI load, I2C data byte
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            wiper_code_r <= MIDSCALE_CODE;
        end else if (sel_s == SEL_SPI && cs_rise) begin
            wiper_code_r <= shift_r;
        end else if (sel_s == SEL_I2C && phase_r == DSW_WDATA && clk_fall
                     && bit_cnt_r == ACK_SLOT) begin
            wiper_code_r <= rs_pend_r ? MIDSCALE_CODE : shift_r;
        end
    end

    // Shutdown flag; code is left untouched
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            shutdown_r <= 1'b0;
        end else if (sel_s == SEL_I2C && phase_r == DSW_WDATA && clk_fall
                     && bit_cnt_r == ACK_SLOT) begin
            shutdown_r <= sd_pend_r;
        end
    end

    // Registered pin and tap outputs
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            sdo_oe_o <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            wiper_code_o <= MIDSCALE_CODE;
            shutdown_o <= 1'b0;
            tap_a_dist_o <= ~MIDSCALE_CODE;
        end else begin
            // pull low only, chain MSB out
            sdo_oe_o <= (sel_s == SEL_SPI) & ~shift_r[7];
            sda_o <= 1'b0;
            sda_oe_o <= ack_slot_r | (rd_en_r & ~tx_r[7]);
            wiper_code_o <= wiper_code_r;
            shutdown_o <= shutdown_r;
            tap_a_dist_o <= 8'hff - wiper_code_r;
        end
    end

    AST_STRAP: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (sel_s && phase_r == DSW_ADDR && clk_fall && bit_cnt_r == ACK_SLOT
         && shift_r[7:1] != {ADDR_HIGH, cs_s}) |=> phase_r == DSW_IGNORE)
        else $error("address mismatch not ignored");
    AST_CSLOAD: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (!sel_s && cs_rise) |=> wiper_code_r == $past(shift_r))
        else $error("chip select rise did not load");
    AST_HOLD: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (!sel_s && !cs_rise) |=> $stable(wiper_code_r))
        else $error("code changed outside transfer");
    AST_SHIFT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (!sel_s && !cs_s && clk_rise) |=> shift_r[0] == $past(dat_s))
        else $error("bit not sampled on rise");
    AST_MID: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (sel_s && phase_r == DSW_WDATA && clk_fall && bit_cnt_r == ACK_SLOT && rs_pend_r)
        |=> wiper_code_r == MIDSCALE_CODE)
        else $error("midscale reset missed");
    AST_RDREL: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (rd_en_r && clk_fall && bit_cnt_r == BITS_PER_BYTE) |=> !rd_en_r)
        else $error("read drive not released");
    AST_SDO: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        sdo_oe_o |-> !$past(shift_r[7]))
        else $error("chain output wrong");
    AST_TAPA: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ##1 (tap_a_dist_o + wiper_code_o == 8'hff))
        else $error("taps not complementary");
    AST_SDCODE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(shutdown_r) |-> ##[1:2] wiper_code_o == wiper_code_r)
        else $error("shutdown disturbed code");
    COV_SPI: cover property (@(posedge mclk_i) !sel_s && cs_rise);
    COV_WR: cover property (@(posedge mclk_i) phase_r == DSW_WDATA);
    COV_RD: cover property (@(posedge mclk_i) phase_r == DSW_RDATA);
    COV_SD: cover property (@(posedge mclk_i) $rose(shutdown_r));
endmodule : dsw_wiper_ctrl

// *** hw/dsw_pkg.sv ***
package dsw_pkg;
    // Wiper code width and power-on midscale preset
    localparam int CODE_W = 8;
    localparam logic [7:0] MIDSCALE_CODE = 8'h80;
    // Fixed upper six bits of the serial address
    localparam logic [5:0] ADDR_HIGH = 6'h16;
    // Instruction byte field positions
    localparam int INSTR_RS_POS = 6;
    localparam int INSTR_SD_POS = 5;
    // Address byte read/write bit position
    localparam int ADDR_RW_POS = 0;
    // Bits per byte and the ninth (acknowledge) slot
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    // Protocol selector levels
    localparam logic SEL_SPI = 1'b0;
    localparam logic SEL_I2C = 1'b1;
    // Serial slave phases
    typedef enum logic [2:0] {
        DSW_IDLE,
        DSW_ADDR,
        DSW_INSTR,
        DSW_WDATA,
        DSW_RDATA,
        DSW_IGNORE
    } dsw_phase_t;
endpackage : dsw_pkg

// *** hw/dsw_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module dsw_sync (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [4:0] async_i,
    output logic [4:0] sync_o
);
    // First stage, read only by the second
    logic [4:0] meta_r;

    // Plain double flop; reset value is idle bus levels
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            meta_r <= 5'h1f;
            sync_o <= 5'h1f;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : dsw_sync

// *** test/dsw_host.sv ***
`timescale 1ns/1ps
// Host model: bit-banged SPI or I2C master
module dsw_host (
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic sel_o,
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdo_o
);
    initial begin
        sel_o = 1'b0;
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdo_o = 1'b1;
    end
    // Changes land just after an edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : step
    task automatic mode(input logic sel, input logic strap);
        sel_o = sel;
        cs_n_o = strap;
        step(8);
    endtask : mode
    // data set while clock is low
    task automatic put(input logic b);
        sdo_o = b;
        step(4);
        sclk_o = 1'b1;
        step(4);
        sclk_o = 1'b0;
    endtask : put
    // Released line reads the pull-up
    task automatic get(output logic b);
        sdo_o = 1'b1;
        step(4);
        sclk_o = 1'b1;
        step(3);
        b = sda_i;
        step(1);
        sclk_o = 1'b0;
    endtask : get
    // eight or sixteen bits, MSB first
    task automatic spi(input logic [15:0] w, input logic long);
        sclk_o = 1'b0;
        step(4);
        cs_n_o = 1'b0;
        step(4);
        for (int i = long ? 15 : 7; i >= 0; i--) put(w[i]);
        step(4);
        cs_n_o = 1'b1;
        step(8);
    endtask : spi
    // start: data falls while clock high
    task automatic start();
        sdo_o = 1'b1;
        step(4);
        sclk_o = 1'b1;
        step(4);
        sdo_o = 1'b0;
        step(4);
        sclk_o = 1'b0;
    endtask : start
    task automatic stop();
        sdo_o = 1'b0;
        step(4);
        sclk_o = 1'b1;
        step(4);
        sdo_o = 1'b1;
        step(8);
    endtask : stop
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put(b[i]);
        get(a);
        ack = ~a;
    endtask : wbyte
    task automatic rbyte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) get(b[i]);
        put(1'b1);
    endtask : rbyte
endmodule : dsw_host

// *** test/dsw_wiper_ctrl_bench.sv ***
`timescale 1ns/1ps
// Bench: host transfers, then port checks
module dsw_wiper_ctrl_bench;
    import dsw_pkg::*;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic sel, cs_n, sclk, sdo_h, sdo_oe, sda_o, sda_oe, shutdown, ack;
    logic [7:0] wiper, tap, rd;
    int bad_count = 0;
    int num_checks = 0;
    // Wired-AND data line with pull-up
    wire sda_line = sdo_h & ~sda_oe;
    dsw_host i_dsw_host (.mclk_i(mclk_i), .sda_i(sda_line), .sel_o(sel), .cs_n_o(cs_n),
        .sclk_o(sclk), .sdo_o(sdo_h));
    dsw_wiper_ctrl i_dsw_wiper_ctrl (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .interface_select_i(sel), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sda_line),
        .sdo_oe_o(sdo_oe), .sda_o(sda_o), .sda_oe_o(sda_oe), .wiper_code_o(wiper),
        .shutdown_o(shutdown), .tap_a_dist_o(tap));
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk1
    // Tap distance checked only outside shutdown
    task automatic chk_state(input logic [7:0] code, input logic sd);
        chk8(wiper, code);
        chk1(shutdown, sd);
        if (!sd) chk8(tap, ~code);
    endtask : chk_state
    // Write: address, instruction, optional data
    task automatic i2c_wr(input logic [7:0] a, input logic [7:0] ins, input logic [7:0] d,
        input logic full);
        i_dsw_host.start();
        i_dsw_host.wbyte(a, ack);
        chk1(ack, 1'b1);
        i_dsw_host.wbyte(ins, ack);
        chk1(ack, 1'b1);
        if (full) begin
            i_dsw_host.wbyte(d, ack);
            chk1(ack, 1'b1);
        end
        i_dsw_host.stop();
    endtask : i2c_wr
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    // Watchdog well beyond the expected run
    initial begin
        #1000000;
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge mclk_i);
        #1 nrst_i = 1'b1;
        i_dsw_host.step(4);
        chk_state(MIDSCALE_CODE, 1'b0);
        i_dsw_host.spi(16'h003c, 1'b0);
        chk_state(8'h3c, 1'b0);
        chk1(sdo_oe, 1'b1);
        i_dsw_host.spi(16'h12a5, 1'b1);
        chk_state(8'ha5, 1'b0);
        chk1(sdo_oe, 1'b0);
        i_dsw_host.mode(SEL_I2C, 1'b0);
        i2c_wr(8'h58, 8'h00, 8'h66, 1'b1);
        chk_state(8'h66, 1'b0);
        i_dsw_host.mode(SEL_I2C, 1'b1);
        i2c_wr(8'h5a, 8'h00, 8'h44, 1'b1);
        chk_state(8'h44, 1'b0);
        i_dsw_host.spi(16'h005a, 1'b0);
        chk_state(8'h44, 1'b0);
        chk1(sdo_oe, 1'b0);
        chk1(sda_o, 1'b0);
        i_dsw_host.start();
        i_dsw_host.wbyte(8'h5b, ack);
        chk1(ack, 1'b1);
        i_dsw_host.rbyte(rd);
        i_dsw_host.stop();
        chk8(rd, 8'h44);
        i_dsw_host.start();
        i_dsw_host.wbyte(8'h58, ack);
        chk1(ack, 1'b0);
        i_dsw_host.wbyte(8'h00, ack);
        i_dsw_host.wbyte(8'h11, ack);
        i_dsw_host.stop();
        chk_state(8'h44, 1'b0);
        i2c_wr(8'h5a, 8'h40, 8'h00, 1'b0);
        chk_state(8'h44, 1'b0);
        i2c_wr(8'h5a, 8'h40, 8'h11, 1'b1);
        chk_state(MIDSCALE_CODE, 1'b0);
        i2c_wr(8'h5a, 8'h20, 8'h22, 1'b1);
        chk_state(8'h22, 1'b1);
        i2c_wr(8'h5a, 8'h9f, 8'h33, 1'b1);
        chk_state(8'h33, 1'b0);
        give_verdict();
    end
endmodule : dsw_wiper_ctrl_bench
